// File: bench/ssfc_codec_model.sv
// Behavioural model of the external codec on the receive pins
`timescale 1ns/1ps
`default_nettype none
module ssfc_codec_model (
  input  wire logic link_clk_i,
  input  wire logic loop_i,
  input  wire logic ckp_i,
  input  wire logic fsp_i,
  input  wire logic fsr_i,
  input  wire logic tx_i,
  input  wire logic tx_oe_i,
  output logic      sck_o,
  output logic      fs_o,
  output logic      data_o
);
  logic d = 1'b0;
  logic act;
  initial sck_o = 1'b0;
  initial fs_o = 1'b0;
  // Shared line while loop_i is set; a released line shows the inverse
  assign data_o = loop_i ? (tx_oe_i ? tx_i : !tx_i) : d;
  // Clock stands still between frames; halves last 3 link cycles
  task send(input logic [15:0] w);
    int b;
    for (b = 0; b < 19; b++) begin
      repeat (3) @(posedge link_clk_i);
      // Drive on the edge leaving the idle level
      sck_o <= !ckp_i;
      act = fsr_i ? (b >= 1 && b <= 16) : (b >= 2 && b <= 17);
      fs_o <= fsp_i ^ act;
      d <= (b >= 2 && b <= 17) ? w[17-b] : !d;
      repeat (3) @(posedge link_clk_i);
      sck_o <= ckp_i;
    end
  endtask : send
endmodule : ssfc_codec_model
`default_nettype wire

// File: bench/ssfc_port_checker.sv
// Assertion checker for the serial port clock and frame configuration block
`timescale 1ns/1ps
`default_nettype none
module ssfc_port_checker
  import ssfc_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              link_clk_i,
  input wire logic              tx_sck_o,
  input wire logic              tx_fs_o,
  input wire logic [NUM_TX-1:0] tx_data_oe_o
);
  logic [23:0] sh;
  logic [23:0] cl;
  logic [6:0]  age;
  logic [5:0]  na;
  logic        ok;
  logic        act;
  logic        tw;
  // ==========================================
  // Shadow of the control word
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      sh <= CTRL_B_RESET;
    else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && paddr_i == OFF_CTRL_B)
      sh <= pwdata_i[23:0];
  end
  // Raw crossing is safe: checks wait until the copy has been stable for long
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cl  <= CTRL_B_RESET;
      age <= 7'h00;
    end else begin
      cl  <= sh;
      age <= (cl != sh) ? 7'h00 : age + {6'h00, age != 7'h7F};
    end
  end
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i)
      na <= 6'h00;
    else
      na <= act ? na + 6'h01 : 6'h00;
  end
  assign ok  = age == 7'h7F;
  assign act = tx_fs_o ^ cl[FSP_BIT];
  assign tw  = cl[FSL_LSB+:2] == FSL_RW_TW || cl[FSL_LSB+:2] == FSL_RB_TW;
  // ==========================================
  // Properties
  property p_wait;
    @(posedge core_clk_i) disable iff (rst_i) psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_edge;
    @(posedge link_clk_i) disable iff (rst_i) ok && $changed(tx_fs_o) |-> tx_sck_o == !cl[CKP_BIT];
  endproperty
  a_edge: assert property (p_edge) else $error("sync moved on wrong edge");
  property p_len;
    @(posedge link_clk_i) disable iff (rst_i) ok && $fell(act) |-> na == (tw ? 6'h20 : 6'h02);
  endproperty
  a_len: assert property (p_len) else $error("sync length wrong");
  property p_r9;
    @(posedge link_clk_i) disable iff (rst_i)
    ok && tw && !cl[FSR_BIT] && cl[TE0_BIT] |-> act == tx_data_oe_o[0];
  endproperty
  a_r9: assert property (p_r9) else $error("word sync not on slot");
  property p_r10;
    @(posedge link_clk_i) disable iff (rst_i)
    ok && tw && cl[FSR_BIT] && cl[TE0_BIT] && $rose(act) |-> !tx_data_oe_o[0] ##2 tx_data_oe_o[0];
  endproperty
  a_r10: assert property (p_r10) else $error("early sync wrong");
  property p_r8;
    @(posedge link_clk_i) disable iff (rst_i)
    ok && !tw && cl[TE0_BIT] && $fell(act) |-> $rose(tx_data_oe_o[0]);
  endproperty
  a_r8: assert property (p_r8) else $error("bit sync moved");
  property p_r11;
    @(posedge link_clk_i) disable iff (rst_i) ok && !cl[SYN_BIT] |-> tx_data_oe_o[2:1] == 2'h0;
  endproperty
  a_r11: assert property (p_r11) else $error("extra transmitter in async");
  property p_r3;
    @(posedge link_clk_i) disable iff (rst_i)
    ok && cl[SYN_BIT] && cl[TE0_BIT] && cl[TE1_BIT] |-> tx_data_oe_o[1] == tx_data_oe_o[0];
  endproperty
  a_r3: assert property (p_r3) else $error("second transmitter idle");
  c_tx1: cover property (@(posedge link_clk_i) ok && $rose(tx_data_oe_o[1]));
  c_err: cover property (@(posedge core_clk_i) pready_o && pslverr_o);
  c_word: cover property (@(posedge link_clk_i) ok && tw && $fell(act));
endmodule : ssfc_port_checker
bind ssfc_port ssfc_port_checker u_ssfc_port_checker (.core_clk_i, .rst_i, .paddr_i, .psel_i,
  .penable_i, .pwrite_i, .pwdata_i, .pready_o, .pslverr_o, .link_clk_i, .tx_sck_o, .tx_fs_o,
  .tx_data_oe_o);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench for the serial port clock and frame configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ssfc_pkg::*;
;
  logic              clk = 1'b0;
  logic              lclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sck;
  logic              fs;
  logic [NUM_TX-1:0] txd;
  logic [NUM_TX-1:0] oe;
  logic              rsck;
  logic              rfs;
  logic              rdat;
  logic              loop = 1'b0;
  logic [23:0]       cfg = '0;
  logic [31:0]       rd;
  logic              er;
  logic [15:0]       w;
  logic              fl;
  logic [4:0]        tbl [5] = '{5'h00, 5'h1C, 5'h09, 5'h16, 5'h07};
  int                err_total = 0;
  int                n_compared = 0;
  always #5 clk = !clk;
  // Link rising edges never meet core rising edges, so the domains stay unrelated
  always #24 lclk = !lclk;
  ssfc_port u_ssfc_port (.core_clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link_clk_i(lclk), .tx_sck_o(sck), .tx_fs_o(fs),
    .tx_data_o(txd), .tx_data_oe_o(oe), .rx_sck_i(rsck), .rx_fs_i(rfs), .rx_data_i(rdat));
  ssfc_codec_model u_ssfc_codec_model (.link_clk_i(lclk), .loop_i(loop), .ckp_i(cfg[CKP_BIT]),
    .fsp_i(cfg[FSP_BIT]), .fsr_i(cfg[FSR_BIT]), .tx_i(txd[0]), .tx_oe_i(oe[0]), .sck_o(rsck),
    .fs_o(rfs), .data_o(rdat));
  // ==========================================
  // Shared tasks
  task stop_test;
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task setc(input logic [4:0] f, input logic syn, input logic re, input logic [2:0] te);
    logic [23:0] v;
    v = '0;
    {v[CKP_BIT], v[FSP_BIT], v[FSR_BIT], v[FSL_LSB+:2]} = f;
    {v[SYN_BIT], v[RE_BIT], v[TE2_BIT], v[TE1_BIT], v[TE0_BIT]} = {syn, re, te};
    apb(1'b1, OFF_CTRL_B, {8'h00, v});
    cfg <= v;
  endtask : setc
  // Collects the next slot of transmitter i on its sampling edges
  task cap(input int i);
    int n;
    int k;
    n = 0;
    k = 0;
    while (oe[i] !== 1'b0 && n < 200) begin
      @(posedge lclk);
      n++;
    end
    while (k < 16 && n < 400) begin
      @(posedge lclk);
      n++;
      if (oe[i] === 1'b1 && sck === !cfg[CKP_BIT]) begin
        w = {w[14:0], txd[i]};
        fl = fs;
        k++;
      end
    end
    if (k < 16)
      err_total++;
  endtask : cap
  // ==========================================
  // Scenarios
  task t_regs;
    for (int a = 0; a <= 8'h14; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, OFF_CTRL_B, 32'hFFFFFFFF);
    apb(1'b0, OFF_CTRL_B, 32'h0);
    chk(rd, 32'h00FFFFFF);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask : t_regs
  task t_tx;
    logic [15:0] wv;
    for (int j = 0; j < 5; j++) begin
      wv = 16'hA5C3 + 16'(j) * 16'h1357;
      setc(tbl[j], 1'b0, 1'b0, 3'h1);
      apb(1'b1, OFF_TX0, {16'h0000, wv});
      repeat (140) @(posedge lclk);
      cap(0);
      chk(w, wv);
      chk(fl, cfg[FSP_BIT] ^ (!cfg[FSR_BIT] && cfg[FSL_LSB] == cfg[FSL_LSB+1]));
    end
  endtask : t_tx
  task t_multi;
    logic [1:0] acc;
    acc = 2'h0;
    setc(5'h00, 1'b0, 1'b0, 3'h7);
    apb(1'b1, OFF_TX0, 32'h6E29);
    apb(1'b1, OFF_TX1, 32'h0F0F);
    apb(1'b1, OFF_TX2, 32'hF00F);
    repeat (140) @(posedge lclk);
    repeat (70) begin
      @(posedge lclk);
      acc = acc | oe[2:1];
    end
    chk(acc, 2'h0);
    setc(5'h00, 1'b1, 1'b1, 3'h7);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[ST_SYNC_MODE], 1'b1);
    loop <= 1'b1;
    repeat (140) @(posedge lclk);
    cap(1);
    chk(w, 16'h0F0F);
    cap(2);
    chk(w, 16'hF00F);
    apb(1'b0, OFF_RX, 32'h0);
    chk(rd, 32'h6E29);
    loop <= 1'b0;
  endtask : t_multi
  task t_rx;
    logic [15:0] wv;
    for (int j = 0; j < 5; j++) begin
      wv = 16'h3C96 ^ (16'(j) * 16'h4321);
      setc(tbl[j], 1'b0, 1'b1, 3'h0);
      repeat (20) @(posedge lclk);
      apb(1'b0, OFF_RX, 32'h0);
      u_ssfc_codec_model.send(wv);
      repeat (20) @(posedge clk);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd[ST_RX_FULL], 1'b1);
      apb(1'b0, OFF_RX, 32'h0);
      chk(rd, {16'h0000, wv});
    end
  endtask : t_rx
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tx;
    t_multi;
    t_rx;
    stop_test;
  end
  // Whole run needs about 110 us
  initial begin
    #900000;
    err_total++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire

// File: include/ssfc_pkg.sv
// Shared constants and types for the serial port clock and frame configuration block
package ssfc_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_CTRL_B      = 8'h00;
  localparam logic [7:0]  OFF_TX0         = 8'h04;
  localparam logic [7:0]  OFF_TX1         = 8'h08;
  localparam logic [7:0]  OFF_TX2         = 8'h0C;
  localparam logic [7:0]  OFF_RX          = 8'h10;
  localparam logic [7:0]  OFF_STATUS      = 8'h14;

  // ==========================================================
  // Control register B fields
  localparam int          CTRL_B_W        = 24;
  localparam logic [23:0] CTRL_B_RESET    = 24'h000000;
  localparam int          FSL_LSB         = 7;
  localparam int          FSR_BIT         = 9;
  localparam int          FSP_BIT         = 10;
  localparam int          CKP_BIT         = 11;
  localparam int          SYN_BIT         = 12;
  localparam int          TE2_BIT         = 14;
  localparam int          TE1_BIT         = 15;
  localparam int          TE0_BIT         = 16;
  localparam int          RE_BIT          = 17;

  // Frame sync length codes: receive length, transmit length
  localparam logic [1:0]  FSL_RW_TW       = 2'h0;
  localparam logic [1:0]  FSL_RW_TB       = 2'h1;
  localparam logic [1:0]  FSL_RB_TB       = 2'h2;
  localparam logic [1:0]  FSL_RB_TW       = 2'h3;

  // Status bits
  localparam int          ST_RX_FULL      = 0;
  localparam int          ST_TX_PEND      = 1;
  localparam int          ST_SYNC_MODE    = 2;

  // ==========================================================
  // Framing
  localparam int          WORD_BITS       = 16;
  localparam int          FRAME_WORDS     = 2;
  localparam int          FRAME_BITS      = WORD_BITS * FRAME_WORDS;
  localparam int          POS_W           = $clog2(FRAME_BITS);
  localparam int          CNT_W           = $clog2(WORD_BITS) + 1;
  localparam int          NUM_TX          = 3;

  typedef struct packed {
    logic       rx_en;
    logic       tx0_en;
    logic       tx1_en;
    logic       tx2_en;
    logic       sync_mode;
    logic       bit_clock_polarity;
    logic       frame_sync_polarity;
    logic       frame_sync_relative_timing;
    logic [1:0] frame_sync_length_sel;
  } ssfc_cfg_t;

  typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_SHIFT} ssfc_rx_state_t;

endpackage : ssfc_pkg

// File: src/ssfc_port.sv
// Serial port with programmable clock edges, frame sync polarity, length and timing
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With the synchronous-select bit clear, receive uses its own bit clock and frame sync pins.
// - With it set, receive shares the transmit bit clock and frame sync made by the port.
// - More than one transmitter may be active in a frame only in synchronous mode.
// - With clock polarity clear, data and sync change on the rising and are sampled on the falling edge.
// - With clock polarity set, data and sync change on the falling and are sampled on the rising edge.
// - With frame sync polarity clear, both frame syncs are active high.
// - With frame sync polarity set, both frame syncs are active low.
// - Relative timing only moves a word-length frame sync, never a bit-length one.
// - With relative timing clear, a word-length sync starts with the first data bit.
// - With relative timing set, a word-length sync starts one bit early, on the previous last bit.
// - Enables of transmitters two and three are ignored in asynchronous mode.
module ssfc_port
  import ssfc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              link_clk_i,
  output logic                   tx_sck_o,
  output logic                   tx_fs_o,
  output logic      [NUM_TX-1:0] tx_data_o,
  output logic      [NUM_TX-1:0] tx_data_oe_o,
  input  wire logic              rx_sck_i,
  input  wire logic              rx_fs_i,
  input  wire logic              rx_data_i
);

  // ==========================================================
  // Helpers
  function automatic ssfc_cfg_t decode_cfg(input logic [CTRL_B_W-1:0] r);
    ssfc_cfg_t c;
    c.rx_en                      = r[RE_BIT];
    c.tx0_en                     = r[TE0_BIT];
    c.tx1_en                     = r[TE1_BIT];
    c.tx2_en                     = r[TE2_BIT];
    c.sync_mode                  = r[SYN_BIT];
    c.bit_clock_polarity         = r[CKP_BIT];
    c.frame_sync_polarity        = r[FSP_BIT];
    c.frame_sync_relative_timing = r[FSR_BIT];
    c.frame_sync_length_sel      = r[FSL_LSB+1:FSL_LSB];
    return c;
  endfunction : decode_cfg

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL_B) || (a == OFF_TX0) || (a == OFF_TX1) ||
           (a == OFF_TX2) || (a == OFF_RX) || (a == OFF_STATUS);
  endfunction : addr_ok

  function automatic logic tx_word_sync(input logic [1:0] fsl);
    return (fsl == FSL_RW_TW) || (fsl == FSL_RB_TW);
  endfunction : tx_word_sync

  function automatic logic rx_word_sync(input logic [1:0] fsl);
    return (fsl == FSL_RW_TW) || (fsl == FSL_RW_TB);
  endfunction : rx_word_sync

  // ==========================================================
  // Core domain: APB slave
  logic [CTRL_B_W-1:0]  ctrl_b;
  logic [WORD_BITS-1:0] tx_word [0:NUM_TX-1];
  logic [WORD_BITS-1:0] tx_hold [0:NUM_TX-1];
  logic [WORD_BITS-1:0] rx_word;
  logic                 rx_full;
  logic                 tx_dirty;
  logic                 tx_req;
  logic                 tx_ack_s1;
  logic                 tx_ack_s2;
  logic                 rx_tgl_s1;
  logic                 rx_tgl_s2;
  logic                 rx_tgl_s3;
  logic                 access;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 hs_idle;
  logic                 rx_arrive;
  ssfc_cfg_t            cfg;
  ssfc_cfg_t            cfg_hold;
  logic                 tx_ack;
  logic                 rx_tgl;
  logic [WORD_BITS-1:0] rx_hold_l;

  assign cfg       = decode_cfg(ctrl_b);
  assign access    = psel_i & penable_i;
  assign wr_fire   = access & pready_o & pwrite_i;
  assign rd_fire   = access & pready_o & ~pwrite_i;
  assign hs_idle   = (tx_req == tx_ack_s2);
  assign rx_arrive = rx_tgl_s2 ^ rx_tgl_s3;

  // One wait state keeps read data registered
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~addr_ok(paddr_i);
      if (access && !pready_o && !pwrite_i) begin
        if (paddr_i == OFF_CTRL_B) begin
          prdata_o <= {8'h00, ctrl_b};
        end else if (paddr_i == OFF_TX0) begin
          prdata_o <= {16'h0000, tx_word[0]};
        end else if (paddr_i == OFF_TX1) begin
          prdata_o <= {16'h0000, tx_word[1]};
        end else if (paddr_i == OFF_TX2) begin
          prdata_o <= {16'h0000, tx_word[2]};
        end else if (paddr_i == OFF_RX) begin
          prdata_o <= {16'h0000, rx_word};
        end else if (paddr_i == OFF_STATUS) begin
          prdata_o <= {29'h00000000, cfg.sync_mode, tx_dirty | ~hs_idle, rx_full};
        end else begin
          prdata_o <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_b <= CTRL_B_RESET;
    end else if (wr_fire && paddr_i == OFF_CTRL_B) begin
      ctrl_b <= pwdata_i[CTRL_B_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_TX; i++) begin
        tx_word[i] <= 16'h0000;
      end
    end else if (wr_fire) begin
      if (paddr_i == OFF_TX0) begin
        tx_word[0] <= pwdata_i[WORD_BITS-1:0];
      end else if (paddr_i == OFF_TX1) begin
        tx_word[1] <= pwdata_i[WORD_BITS-1:0];
      end else if (paddr_i == OFF_TX2) begin
        tx_word[2] <= pwdata_i[WORD_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // Core to link: transmit words by request and acknowledge toggles
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ack_s1 <= 1'b0;
      tx_ack_s2 <= 1'b0;
    end else begin
      tx_ack_s1 <= tx_ack;
      tx_ack_s2 <= tx_ack_s1;
    end
  end

  // Hold stays frozen until acknowledged, so the link copies stable words
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_req   <= 1'b0;
      tx_dirty <= 1'b0;
      cfg_hold <= '0;
      for (int i = 0; i < NUM_TX; i++) begin
        tx_hold[i] <= 16'h0000;
      end
    end else begin
      if (hs_idle && tx_dirty) begin
        tx_req   <= ~tx_req;
        cfg_hold <= cfg;
        tx_dirty <= 1'b0;
        for (int i = 0; i < NUM_TX; i++) begin
          tx_hold[i] <= tx_word[i];
        end
      end
      // A write in the copy cycle keeps the flag set; control rides along to cross whole
      if (wr_fire && (paddr_i == OFF_CTRL_B || paddr_i == OFF_TX0 ||
                      paddr_i == OFF_TX1 || paddr_i == OFF_TX2)) begin
        tx_dirty <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Link to core: received words
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_tgl_s1 <= 1'b0;
      rx_tgl_s2 <= 1'b0;
      rx_tgl_s3 <= 1'b0;
      rx_word   <= 16'h0000;
      rx_full   <= 1'b0;
    end else begin
      rx_tgl_s1 <= rx_tgl;
      rx_tgl_s2 <= rx_tgl_s1;
      rx_tgl_s3 <= rx_tgl_s2;
      if (rx_arrive) begin
        rx_word <= rx_hold_l;
        rx_full <= 1'b1;
      end else if (rd_fire && paddr_i == OFF_RX) begin
        rx_full <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Link domain: synchronisers
  ssfc_cfg_t            lcfg;
  logic                 tx_req_s1;
  logic                 tx_req_s2;
  logic                 tx_req_s3;
  logic [WORD_BITS-1:0] tx_buf [0:NUM_TX-1];
  logic [WORD_BITS-1:0] tx_cur [0:NUM_TX-1];
  logic                 rx_sck_s1;
  logic                 rx_sck_s2;
  logic                 rx_fs_s1;
  logic                 rx_fs_s2;
  logic                 rx_dat_s1;
  logic                 rx_dat_s2;

  // Request toggle and pin synchronisers; the receive bit clock is oversampled
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_req_s1 <= 1'b0;
      tx_req_s2 <= 1'b0;
      rx_sck_s1 <= 1'b0;
      rx_sck_s2 <= 1'b0;
      rx_fs_s1  <= 1'b0;
      rx_fs_s2  <= 1'b0;
      rx_dat_s1 <= 1'b0;
      rx_dat_s2 <= 1'b0;
    end else begin
      tx_req_s1 <= tx_req;
      tx_req_s2 <= tx_req_s1;
      rx_sck_s1 <= rx_sck_i;
      rx_sck_s2 <= rx_sck_s1;
      rx_fs_s1  <= rx_fs_i;
      rx_fs_s2  <= rx_fs_s1;
      rx_dat_s1 <= rx_data_i;
      rx_dat_s2 <= rx_dat_s1;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_req_s3 <= 1'b0;
      tx_ack    <= 1'b0;
      lcfg      <= '0;
      for (int i = 0; i < NUM_TX; i++) begin
        tx_buf[i] <= 16'h0000;
      end
    end else begin
      tx_req_s3 <= tx_req_s2;
      if (tx_req_s2 ^ tx_req_s3) begin
        tx_ack <= ~tx_ack;
        lcfg   <= cfg_hold;
        for (int i = 0; i < NUM_TX; i++) begin
          tx_buf[i] <= tx_hold[i];
        end
      end
    end
  end

  // ==========================================================
  // Link domain: transmit framing, one bit per two link cycles
  logic             drive_ph;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;
  logic [NUM_TX-1:0] tx_act;
  logic [NUM_TX-1:0] next_act;
  logic             fs_on;

  assign next_pos = (pos == POS_W'(FRAME_BITS - 1)) ? '0 : pos + 1'b1;

  assign next_act = {lcfg.tx2_en & lcfg.sync_mode, lcfg.tx1_en & lcfg.sync_mode, lcfg.tx0_en};

  always_comb begin
    if (!tx_word_sync(lcfg.frame_sync_length_sel)) begin
      fs_on = (next_pos == POS_W'(FRAME_BITS - 1));
    end else if (lcfg.frame_sync_relative_timing) begin
      fs_on = (next_pos == POS_W'(FRAME_BITS - 1)) || (next_pos < POS_W'(WORD_BITS - 1));
    end else begin
      fs_on = (next_pos < POS_W'(WORD_BITS));
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_ph     <= 1'b1;
      pos          <= POS_W'(FRAME_BITS - 1);
      tx_sck_o     <= 1'b0;
      tx_fs_o      <= 1'b0;
      tx_data_o    <= '0;
      tx_data_oe_o <= '0;
      tx_act       <= '0;
      for (int i = 0; i < NUM_TX; i++) begin
        tx_cur[i] <= 16'h0000;
      end
    end else begin
      drive_ph <= ~drive_ph;
      if (drive_ph) begin
        tx_sck_o <= ~lcfg.bit_clock_polarity;
        pos      <= next_pos;
        tx_fs_o  <= fs_on ^ lcfg.frame_sync_polarity;
        if (next_pos == '0) begin
          tx_act <= next_act;
          for (int i = 0; i < NUM_TX; i++) begin
            tx_cur[i]       <= tx_buf[i];
            tx_data_o[i]    <= tx_buf[i][WORD_BITS-1];
            tx_data_oe_o[i] <= next_act[i];
          end
        end else begin
          for (int i = 0; i < NUM_TX; i++) begin
            if (next_pos < POS_W'(WORD_BITS)) begin
              tx_data_o[i] <= tx_cur[i][WORD_BITS-1-int'(next_pos)];
            end
            tx_data_oe_o[i] <= tx_act[i] & (next_pos < POS_W'(WORD_BITS));
          end
        end
      end else begin
        tx_sck_o <= lcfg.bit_clock_polarity;
      end
    end
  end

  // ==========================================================
  // Link domain: receive
  logic                 int_sck_d;
  logic                 int_fs_d;
  logic                 src_sck;
  logic                 src_fs;
  logic                 sck_prev;
  logic                 smp_edge;
  logic                 fs_act;
  logic                 fs_prev;
  logic                 fs_start;
  ssfc_rx_state_t       rx_state;
  logic [CNT_W-1:0]     rx_cnt;
  logic [WORD_BITS-1:0] rx_sh;

  // Delay matches the internal clock to the synchronised data pin
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_sck_d <= 1'b0;
      int_fs_d  <= 1'b0;
      sck_prev  <= 1'b0;
    end else begin
      int_sck_d <= tx_sck_o;
      int_fs_d  <= tx_fs_o;
      sck_prev  <= src_sck;
    end
  end

  assign src_sck  = lcfg.sync_mode ? int_sck_d : rx_sck_s2;
  assign src_fs   = lcfg.sync_mode ? int_fs_d  : rx_fs_s2;
  assign smp_edge = lcfg.bit_clock_polarity ? (src_sck & ~sck_prev) : (~src_sck & sck_prev);
  assign fs_act   = src_fs ^ lcfg.frame_sync_polarity;
  assign fs_start = fs_act & ~fs_prev;

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_prev   <= 1'b0;
      rx_state  <= RX_IDLE;
      rx_cnt    <= '0;
      rx_sh     <= 16'h0000;
      rx_hold_l <= 16'h0000;
      rx_tgl    <= 1'b0;
    end else if (smp_edge) begin
      fs_prev <= fs_act;
      if (!lcfg.rx_en) begin
        rx_state <= RX_IDLE;
      end else if (fs_start && rx_word_sync(lcfg.frame_sync_length_sel) &&
                   !lcfg.frame_sync_relative_timing) begin
        rx_sh    <= {rx_sh[WORD_BITS-2:0], rx_dat_s2};
        rx_cnt   <= CNT_W'(1);
        rx_state <= RX_SHIFT;
      end else if (fs_start) begin
        rx_state <= RX_ARMED;
      end else begin
        case (rx_state)
          RX_ARMED: begin
            rx_sh    <= {rx_sh[WORD_BITS-2:0], rx_dat_s2};
            rx_cnt   <= CNT_W'(1);
            rx_state <= RX_SHIFT;
          end
          RX_SHIFT: begin
            rx_sh  <= {rx_sh[WORD_BITS-2:0], rx_dat_s2};
            rx_cnt <= rx_cnt + 1'b1;
            if (rx_cnt == CNT_W'(WORD_BITS - 1)) begin
              rx_hold_l <= {rx_sh[WORD_BITS-2:0], rx_dat_s2};
              rx_tgl    <= ~rx_tgl;
              rx_state  <= RX_IDLE;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule : ssfc_port

`default_nettype wire
